// ### design/cfs_channel.sv
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "cfs_defines.svh"
module cfs_channel
    import cfs_pkg::*;
#(
    parameter int AW = 8
) (
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // sources, one pulse per event
    input  wire logic [31:0]   sync_sources,
    // fault pin, low means fault
    input  wire logic          fault_input_pin_n,
    // compare pin and trigger out
    output logic               compare_output_pin,
    output logic               compare_output_oe,
    output logic               trigger_out
);

    // refuse address widths that cannot hold the register map
    if (AW < 8) begin : g_aw_check
        $error("cfs_channel: AW too small");
    end

    // ==========================================
    // registers
    // ==========================================
    logic [7:0]  c1_q;        // first control
    cfs_ctrl2_t  c2_q;        // second control
    logic [31:0] pri_q;       // primary compare
    logic [31:0] sec_q;       // secondary compare
    logic [31:0] tmr_q;       // channel timer
    logic [31:0] rd_d;        // read mux
    logic        hit_d;       // address mapped
    logic        wr;          // write completes
    logic        wr1;         // write to ctrl1
    logic        wr2;         // write to ctrl2
    cfs_fst_t    st_q;        // fault state
    logic [2:0]  mprev_q;     // last mode
    logic        cmp_q;       // raw compare out
    logic        shot_q;      // one-shot done
    cfs_pin_t    pin_q;       // registered pin
    logic        tout_q;      // trigger out
    logic [2:0]  fs_q;        // fault pin sync
    logic        flt_q;       // filtered fault
    logic        prdy_q;      // apb ready
    logic        perr_q;      // apb error
    logic [31:0] prd_q;       // apb read data

    cfs_mode_t   mode;        // mode field
    logic [31:0] mask;        // timer width
    logic [31:0] tnext;       // timer + 1
    logic        run;         // timer runs
    logic        pri_m;       // primary match
    logic        sec_m;       // secondary match
    logic        src_evt;     // selected event
    logic        restart;     // sync restart
    logic        pstart;      // period start
    logic        f_evt;       // fault seen now

    // ==========================================
    // source selector
    // ==========================================
    function automatic logic cfs_pick(
        input logic [4:0]  c,
        input logic [31:0] s,
        input logic        own
    );
        logic r;
        r = 1'b0;
        case (c)
            `CFS_SRC_OWN:            r = own;
            5'h1e, 5'h1d, 5'h1c:     r = s[c];
            5'h1b, 5'h1a, 5'h19,
            5'h18, 5'h17, 5'h16:     r = s[c];
            5'h13, 5'h12, 5'h11,
            5'h10:                   r = s[c];
            5'h0f, 5'h0e, 5'h0d,
            5'h0c, 5'h0b:            r = s[c];
            5'h04, 5'h03, 5'h02,
            5'h01:                   r = s[c];
            default:                 r = 1'b0;
        endcase
        return r;
    endfunction : cfs_pick

    // ==========================================
    // apb slave
    // ==========================================
    // two-cycle access: ready rises one cycle in; unmapped writes dropped
    assign wr  = psel & penable & prdy_q & pwrite & ~perr_q;
    assign wr1 = wr & (paddr[7:0] == `CFS_OFF_CTRL1);
    assign wr2 = wr & (paddr[7:0] == `CFS_OFF_CTRL2);

    // read mux and decode
    always_comb begin
        rd_d  = 32'h0;
        hit_d = 1'b1;
        case (paddr[7:0])
            `CFS_OFF_CTRL1: rd_d = {24'h0, c1_q};
            `CFS_OFF_CTRL2: rd_d = {16'h0, c2_q};
            `CFS_OFF_PRI:   rd_d = pri_q;
            `CFS_OFF_SEC:   rd_d = sec_q;
            `CFS_OFF_TMR:   rd_d = tmr_q;
            default:        hit_d = 1'b0;
        endcase
        // any address bit above the byte offset makes it unmapped
        if ((paddr >> 8) != '0) begin
            hit_d = 1'b0;
        end
    end

    // ready, error and read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdy_q <= 1'b0;
            perr_q <= 1'b0;
            prd_q  <= 32'h0;
        end else if (psel && penable && !prdy_q) begin
            prdy_q <= 1'b1;
            perr_q <= ~hit_d;
            prd_q  <= (hit_d && !pwrite) ? rd_d : 32'h0;
        end else begin
            prdy_q <= 1'b0;
            perr_q <= 1'b0;
        end
    end

    assign prdata  = prd_q;
    assign pready  = prdy_q;
    assign pslverr = perr_q;

    // compare values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pri_q <= 32'h0;
            sec_q <= 32'h0;
        end else begin
            if (wr && paddr[7:0] == `CFS_OFF_PRI) begin
                pri_q <= pwdata;
            end
            if (wr && paddr[7:0] == `CFS_OFF_SEC) begin
                sec_q <= pwdata;
            end
        end
    end

    // first control; seen flag: set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c1_q <= `CFS_CTRL1_RST;
        end else begin
            if (wr1) begin
                c1_q[`CFS_B_FLT_EN]  <= pwdata[`CFS_B_FLT_EN];
                c1_q[`CFS_B_CLRMODE] <= pwdata[`CFS_B_CLRMODE];
                c1_q[2:0]            <= pwdata[2:0];
                if (!pwdata[`CFS_B_SEEN]) begin
                    c1_q[`CFS_B_SEEN] <= 1'b0;
                end
            end
            if (f_evt) begin
                c1_q[`CFS_B_SEEN] <= 1'b1;
            end
        end
    end

    // second control; armed flag set beats all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c2_q <= cfs_ctrl2_t'(`CFS_CTRL2_RST);
        end else begin
            if (wr2) begin
                c2_q      <= cfs_ctrl2_t'(pwdata[15:0]);
                c2_q.rsv  <= 3'h0;
            end else if (c1_q[`CFS_B_CLRMODE] && sec_m) begin
                c2_q.armed <= 1'b0;
            end
            if (c2_q.trig_sel && src_evt) begin
                c2_q.armed <= 1'b1;
            end
        end
    end

    // ==========================================
    // timer and matches
    // ==========================================
    assign mode  = cfs_mode_t'(c1_q[2:0]);
    assign mask  = c2_q.cascade ? `CFS_MASK32 : `CFS_MASK16;
    assign tnext = (tmr_q + 32'h1) & mask;
    // trigger mode runs only once armed
    assign run   = (mode != CFS_OFF) &&
                   (!c2_q.trig_sel || c2_q.armed);
    assign pri_m = run && ((tmr_q & mask) == (pri_q & mask));
    assign sec_m = run && ((tmr_q & mask) == (sec_q & mask));
    assign src_evt = cfs_pick(c2_q.src, sync_sources, sec_m);
    // sync mode restarts on the source event
    assign restart = run && !c2_q.trig_sel && src_evt;
    assign pstart  = run && (restart || tnext == 32'h0);

    // timer counter, held at zero when stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_q <= 32'h0;
        end else if (!run || restart) begin
            tmr_q <= 32'h0;
        end else begin
            tmr_q <= tnext;
        end
    end

    // ==========================================
    // fault path
    // ==========================================
    // three-flop sync, level moves when 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_q  <= 3'b111;
            flt_q <= 1'b0;
        end else begin
            fs_q <= {fs_q[1:0], fault_input_pin_n};
            if (fs_q[1] == fs_q[2]) begin
                flt_q <= ~fs_q[2];
            end
        end
    end

    assign f_evt = c1_q[`CFS_B_FLT_EN] && flt_q;

    // fault state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= CFS_NORMAL;
        end else begin
            unique case (st_q)
                CFS_NORMAL: begin
                    if (f_evt) begin
                        st_q <= CFS_FAULTED;
                    end
                end
                CFS_FAULTED: begin
                    // hold select also waits for flag clear
                    if (pstart && !flt_q &&
                        (!c2_q.hold || !c1_q[`CFS_B_SEEN])) begin
                        st_q <= CFS_NORMAL;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // compare output
    // ==========================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mprev_q <= 3'h0;
            cmp_q   <= 1'b0;
            shot_q  <= 1'b0;
        end else begin
            mprev_q <= c1_q[2:0];
            if (c1_q[2:0] != mprev_q) begin
                // new mode loads its initial level
                cmp_q  <= (mode == CFS_SC_LO);
                shot_q <= 1'b0;
            end else begin
                unique case (mode)
                    CFS_OFF:    cmp_q <= 1'b0;
                    CFS_SC_HI:  if (pri_m) cmp_q <= 1'b1;
                    CFS_SC_LO:  if (pri_m) cmp_q <= 1'b0;
                    CFS_SC_TGL: if (pri_m) cmp_q <= ~cmp_q;
                    CFS_DC_ONE: begin
                        if (pri_m && !shot_q) cmp_q <= 1'b1;
                        if (sec_m) begin
                            cmp_q  <= 1'b0;
                            shot_q <= 1'b1;
                        end
                    end
                    CFS_DC_CON, CFS_PWM_C: begin
                        if (pri_m) cmp_q <= 1'b1;
                        if (sec_m) cmp_q <= 1'b0;
                    end
                    CFS_PWM_E: begin
                        if (pstart) cmp_q <= 1'b1;
                        if (pri_m) cmp_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // pin level and enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= '0;
        end else begin
            if (st_q == CFS_FAULTED) begin
                pin_q.level <= c2_q.level;
            end else begin
                pin_q.level <= cmp_q ^ c2_q.invert;
            end
            pin_q.oe <= !(c2_q.out_float ||
                         (st_q == CFS_FAULTED && c2_q.float_en));
        end
    end

    // pulse when the channel is turned off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tout_q <= 1'b0;
        end else begin
            tout_q <= (mprev_q != 3'h0) && (c1_q[2:0] == 3'h0);
        end
    end

    assign compare_output_pin = pin_q.level;
    assign compare_output_oe  = pin_q.oe;
    assign trigger_out        = tout_q;

    // ==========================================
    // assertions
    // ==========================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_hold;
        (st_q == CFS_FAULTED && c2_q.hold && c1_q[`CFS_B_SEEN])
            |=> st_q == CFS_FAULTED;
    endproperty
    a_hold: assert property (p_hold) else $error("held fault released");

    property p_auto;
        (st_q == CFS_FAULTED && !c2_q.hold && pstart && !flt_q)
            |=> st_q == CFS_NORMAL;
    endproperty
    a_auto: assert property (p_auto) else $error("fault not released");

    property p_level;
        (st_q == CFS_FAULTED && !c2_q.float_en && !c2_q.out_float)
            |=> pin_q.oe && pin_q.level == $past(c2_q.level);
    endproperty
    a_level: assert property (p_level) else $error("bad fault level");

    property p_float;
        (st_q == CFS_FAULTED && c2_q.float_en) |=> !pin_q.oe;
    endproperty
    a_float: assert property (p_float) else $error("pin driven in fault");

    property p_inv;
        st_q == CFS_NORMAL |=> pin_q.level == $past(cmp_q ^ c2_q.invert);
    endproperty
    a_inv: assert property (p_inv) else $error("bad inversion");

    property p_held;
        (c2_q.trig_sel && !c2_q.armed) |=> tmr_q == 32'h0;
    endproperty
    a_held: assert property (p_held) else $error("timer ran unarmed");

    property p_arm;
        (c2_q.trig_sel && src_evt) |=> c2_q.armed ##1 (tmr_q != 32'h0 || !run);
    endproperty
    a_arm: assert property (p_arm) else $error("trigger not taken");

    property p_oe;
        c2_q.out_float |=> !pin_q.oe;
    endproperty
    a_oe: assert property (p_oe) else $error("pin not floated");

    property p_tout;
        (mprev_q != 3'h0 && c1_q[2:0] == 3'h0) |=> tout_q ##1 !tout_q;
    endproperty
    a_tout: assert property (p_tout) else $error("no trigger out");

    property p_seen;
        f_evt |=> c1_q[`CFS_B_SEEN];
    endproperty
    a_seen: assert property (p_seen) else $error("fault flag missed");

endmodule : cfs_channel

// ### design/cfs_defines.svh
`ifndef CFS_DEFINES_SVH
`define CFS_DEFINES_SVH
// register byte offsets
`define CFS_OFF_CTRL1  8'h00
`define CFS_OFF_CTRL2  8'h04
`define CFS_OFF_PRI    8'h08
`define CFS_OFF_SEC    8'h0c
`define CFS_OFF_TMR    8'h10
// first control register fields
`define CFS_B_FLT_EN   7
`define CFS_B_SEEN     4
`define CFS_B_CLRMODE  3
// reset values
`define CFS_CTRL1_RST  8'h00
`define CFS_CTRL2_RST  16'h000c
// timer width masks
`define CFS_MASK16     32'h0000ffff
`define CFS_MASK32     32'hffffffff
// selector codes with special meaning
`define CFS_SRC_OWN    5'h1f
`endif

// ### design/cfs_pkg.sv
package cfs_pkg;
    // channel mode field
    typedef enum logic [2:0] {
        CFS_OFF    = 3'h0,
        CFS_SC_HI  = 3'h1,
        CFS_SC_LO  = 3'h2,
        CFS_SC_TGL = 3'h3,
        CFS_DC_ONE = 3'h4,
        CFS_DC_CON = 3'h5,
        CFS_PWM_E  = 3'h6,
        CFS_PWM_C  = 3'h7
    } cfs_mode_t;
    // fault state, gray along the path
    typedef enum logic {
        CFS_NORMAL  = 1'b0,
        CFS_FAULTED = 1'b1
    } cfs_fst_t;
    // second control register layout
    typedef struct packed {
        logic       hold;
        logic       level;
        logic       float_en;
        logic       invert;
        logic [2:0] rsv;
        logic       cascade;
        logic       trig_sel;
        logic       armed;
        logic       out_float;
        logic [4:0] src;
    } cfs_ctrl2_t;
    // compare pin carrier
    typedef struct packed {
        logic level;
        logic oe;
    } cfs_pin_t;
endpackage : cfs_pkg

// ### bench/cfs_load.sv
`timescale 1ns/1ps
// ==========================================================
// external load on the compare pin, with a weak pull-down
module cfs_load
    import cfs_pkg::*;
(
    // pin as the channel drives it
    input  wire cfs_pin_t pin,
    // level at the load and whether anyone drives it
    output logic          pad,
    output logic          driven
);
    // a released pin is pulled low by the load resistor
    assign pad    = pin.oe ? pin.level : 1'b0;
    assign driven = pin.oe;
endmodule : cfs_load

// ### bench/compare_channel_fault_sync_control_tb_top.sv
`timescale 1ns/1ps
`include "cfs_defines.svh"
// one compare: counts it and reports a mismatch at once
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin err_count++; \
    $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module compare_channel_fault_sync_control_tb_top
    import cfs_pkg::*;
;
    // ==========================================================
    // bench signals
    logic        pclk, presetn, psel, penable, pwrite;  // clock, reset, apb controls
    logic [7:0]  paddr;                                 // apb address
    logic [31:0] pwdata, prdata, sync_sources, rd, v;   // apb data, sources, scratch
    logic        pready, pslverr, serr, fault_input_pin_n;
    logic        compare_output_pin, compare_output_oe, trigger_out, pad, driven;
    cfs_pin_t    pin;                                   // pin carrier to the load
    int          err_count, check_count, c, t0;         // counters and scratch
    int          trig_cnt = 0;                          // trigger-out pulses seen
    int          seed = 32'h6a802aee;                   // fixed random seed
    // model: selector codes that restart the timer on their own pulse
    int          sync_q[$] = '{1, 2, 3, 4, 11, 12, 13, 14, 15, 16, 17, 18, 19,
                               22, 23, 24, 25, 26, 27, 28, 29, 30};
    // model: modes not reached by the other scenarios
    int          mq[$] = '{3, 4, 5, 7};

    // ==========================================================
    // design, load and clock
    cfs_channel u_cfs_channel (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sync_sources(sync_sources), .fault_input_pin_n(fault_input_pin_n),
        .compare_output_pin(compare_output_pin), .compare_output_oe(compare_output_oe),
        .trigger_out(trigger_out));
    assign pin = '{level: compare_output_pin, oe: compare_output_oe};
    cfs_load u_cfs_load (.pin(pin), .pad(pad), .driven(driven));
    // clock generator
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // count trigger-out pulses
    always @(posedge pclk) begin
        if (trigger_out === 1'b1) begin
            trig_cnt <= trig_cnt + 1;
        end
    end

    // ==========================================================
    // tasks
    // verdict and end of run
    task complete_run();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    // one apb transfer, called just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        serr = pslverr;
        if (pready !== 1'b1) begin
            err_count++;
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // read a register and compare it
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        `CHK(nm, ex, rd)
    endtask : rdchk
    // wait whole cycles
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    // one-cycle source pulse
    task automatic pulse(input logic [31:0] s);
        sync_sources <= s & 32'h7fffffff;
        @(posedge pclk);
        sync_sources <= 32'h0;
        @(posedge pclk);
    endtask : pulse
    // model lookup of restarting codes
    function automatic logic mapped(input int code);
        foreach (sync_q[i]) if (sync_q[i] == code) return 1'b1;
        return 1'b0;
    endfunction : mapped

    // ==========================================================
    // main sequence
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h0; pwdata = 32'h0; sync_sources = 32'h0; fault_input_pin_n = 1'b1;
        err_count = 0; check_count = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, read-only timer, unmapped offset
        rdchk("ctrl2_rst", `CFS_OFF_CTRL2, 32'h0000000c);
        rdchk("ctrl1_rst", `CFS_OFF_CTRL1, 32'h0);
        `CHK("oe_rst", 1'b1, driven)
        apb(1'b1, `CFS_OFF_TMR, $random(seed));
        rdchk("tmr_ro", `CFS_OFF_TMR, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        `CHK("unmapped", 1'b1, serr)
        // random control values read back without reserved bits
        repeat (4) begin
            v = $random(seed);
            apb(1'b1, `CFS_OFF_CTRL2, v);
            rdchk("ctrl2_rw", `CFS_OFF_CTRL2, v & 32'h0000f1ff);
        end
        // mode 010 starts high; invert and float select
        apb(1'b1, `CFS_OFF_CTRL2, 32'h0000000c);
        apb(1'b1, `CFS_OFF_PRI, 32'h00008000);
        apb(1'b1, `CFS_OFF_CTRL1, 32'h2);
        cyc(4);
        `CHK("mode010", 1'b1, pad)
        apb(1'b1, `CFS_OFF_CTRL2, 32'h0000100c);
        cyc(4);
        `CHK("invert", 1'b0, pad)
        apb(1'b1, `CFS_OFF_CTRL2, 32'h0000102c);
        cyc(4);
        `CHK("float", 1'b0, driven)
        // turning off sends one trigger-out pulse, a second off sends none
        t0 = trig_cnt;
        apb(1'b1, `CFS_OFF_CTRL1, 32'h0);
        cyc(4);
        `CHK("trig_out", 1, trig_cnt - t0)
        apb(1'b1, `CFS_OFF_CTRL1, 32'h0);
        cyc(4);
        `CHK("trig_out_once", 1, trig_cnt - t0)
        // selector codes 0 to 30: other pulses ignored, own pulse restarts if mapped
        apb(1'b1, `CFS_OFF_CTRL1, 32'h1);
        for (c = 0; c < 31; c++) begin
            apb(1'b1, `CFS_OFF_CTRL2, c);
            cyc(30);
            pulse(~(32'h1 << c));
            apb(1'b0, `CFS_OFF_TMR, 32'h0);
            `CHK("no_restart", 1'b1, rd >= 10)
            pulse(32'h1 << c);
            apb(1'b0, `CFS_OFF_TMR, 32'h0);
            `CHK("restart", mapped(c), rd < 10)
        end
        // code 11111 restarts on the secondary match
        apb(1'b1, `CFS_OFF_SEC, 32'h14);
        apb(1'b1, `CFS_OFF_CTRL2, 32'h1f);
        cyc(100);
        apb(1'b0, `CFS_OFF_TMR, 32'h0);
        `CHK("own_match", 1'b1, rd <= 32'h14)
        // cascade: upper half of the compare matters only at 32 bits
        apb(1'b1, `CFS_OFF_PRI, 32'h00010005);
        for (c = 0; c < 2; c++) begin
            apb(1'b1, `CFS_OFF_CTRL1, 32'h0);
            apb(1'b1, `CFS_OFF_CTRL2, c ? 32'h1 : 32'h101);
            apb(1'b1, `CFS_OFF_CTRL1, 32'h1);
            pulse(32'h2);
            cyc(20);
            `CHK("cascade", c[0], pad)
        end
        // trigger operation: held at zero until the source fires
        apb(1'b1, `CFS_OFF_CTRL2, 32'h0000008c);
        cyc(10);
        rdchk("held", `CFS_OFF_TMR, 32'h0);
        pulse(32'h1 << 12);
        rdchk("armed", `CFS_OFF_CTRL2, 32'h000000cc);
        apb(1'b0, `CFS_OFF_TMR, 32'h0);
        `CHK("running", 1'b1, rd > 0)
        // auto-clear on the secondary match
        apb(1'b1, `CFS_OFF_SEC, 32'h40);
        apb(1'b1, `CFS_OFF_CTRL1, 32'h9);
        cyc(100);
        rdchk("autoclr", `CFS_OFF_CTRL2, 32'h0000008c);
        rdchk("held2", `CFS_OFF_TMR, 32'h0);
        // with clear mode off only software clears the flag
        apb(1'b1, `CFS_OFF_CTRL1, 32'h1);
        pulse(32'h1 << 12);
        cyc(100);
        rdchk("noautoclr", `CFS_OFF_CTRL2, 32'h000000cc);
        // faults in edge pwm, first with the input disabled
        apb(1'b1, `CFS_OFF_CTRL2, 32'h0000400c);
        apb(1'b1, `CFS_OFF_PRI, 32'h5);
        apb(1'b1, `CFS_OFF_CTRL1, 32'h6);
        pulse(32'h1 << 12);
        fault_input_pin_n <= 1'b0;
        cyc(10);
        rdchk("flt_ignored", `CFS_OFF_CTRL1, 32'h6);
        `CHK("flt_off_pad", 1'b0, pad)
        apb(1'b1, `CFS_OFF_CTRL1, 32'h86);
        cyc(10);
        rdchk("flt_seen", `CFS_OFF_CTRL1, 32'h96);
        `CHK("flt_level", 1'b1, pad)
        apb(1'b1, `CFS_OFF_CTRL2, 32'h0000600c);
        cyc(4);
        `CHK("flt_float", 1'b0, driven)
        // no hold: leaves at the next period start with the flag still set
        fault_input_pin_n <= 1'b1;
        cyc(10);
        `CHK("flt_wait", 1'b0, driven)
        pulse(32'h1 << 12);
        cyc(6);
        `CHK("flt_end", 1'b1, driven)
        // hold: period start alone is not enough, the flag must be cleared
        apb(1'b1, `CFS_OFF_CTRL2, 32'h0000e00c);
        fault_input_pin_n <= 1'b0;
        cyc(10);
        fault_input_pin_n <= 1'b1;
        cyc(8);
        pulse(32'h1 << 12);
        cyc(6);
        `CHK("hold_wait", 1'b0, driven)
        apb(1'b1, `CFS_OFF_CTRL1, 32'h86);
        pulse(32'h1 << 12);
        cyc(6);
        `CHK("hold_end", 1'b1, driven)
        // low fault level is not inverted
        apb(1'b1, `CFS_OFF_CTRL2, 32'h0000100c);
        fault_input_pin_n <= 1'b0;
        cyc(12);
        `CHK("flt_low", 1'b0, pad)
        fault_input_pin_n <= 1'b1;
        cyc(4);
        // remaining modes from a stopped timer: toggle, one-shot, continuous, centre
        apb(1'b1, `CFS_OFF_CTRL2, 32'h0000000c);
        apb(1'b1, `CFS_OFF_PRI, 32'h5);
        apb(1'b1, `CFS_OFF_SEC, 32'ha);
        pulse(32'h1 << 12);
        foreach (mq[i]) begin
            apb(1'b1, `CFS_OFF_CTRL1, 32'h0);
            apb(1'b1, `CFS_OFF_CTRL1, mq[i]);
            cyc(8);
            `CHK("mode_pri", 1'b1, pad)
            cyc(6);
            `CHK("mode_sec", mq[i] == 3, pad)
            pulse(32'h1 << 12);
            cyc(8);
            `CHK("mode_next", mq[i] == 5 || mq[i] == 7, pad)
        end
        complete_run();
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge pclk);
        err_count++;
        complete_run();
    end
endmodule : compare_channel_fault_sync_control_tb_top
